// file: tb/nfbbp_ctrl_asserts.sv
// nfbbp_ctrl_asserts.sv: pin protocol checker for the flash host controller
`timescale 1ns/10ps
module nfbbp_ctrl_chk #(
	parameter AW = 23
) (
	input wire clk_sys,
	input wire srst,
	input wire cmd_valid,
	input wire cmd_ready,
	input wire [2:0] cmd_op,
	input wire [5:0] cmd_count,
	input wire byte_mode,
	input wire rsp_valid,
	input wire rsp_err,
	input wire [AW-1:0] flash_addr,
	input wire flash_a9_hv,
	input wire flash_ce_n,
	input wire flash_oe_n,
	input wire flash_we_n,
	input wire flash_rst_n,
	input wire flash_wp_low,
	input wire flash_acc_hv,
	input wire [15:0] dq_o,
	input wire [15:0] dq_oe
);
	// **********
	// helpers
	// **********
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	reg [4:0] rst_len_r;
	wire take = cmd_valid && cmd_ready;
	// saturates so a long reset pulse cannot wrap to a short count
	always @(posedge clk_sys) begin
		if (flash_rst_n)
			rst_len_r <= 5'h00;
		else if (rst_len_r != 5'h1F)
			rst_len_r <= rst_len_r + 5'h01;
	end
	// **********
	// assertions
	// **********
	a_read_strobes: assert property (!flash_oe_n |->
		!flash_ce_n && flash_we_n && dq_oe[14:0] == 15'h0000)
		else $error("read strobes wrong");
	a_write_levels: assert property (!flash_we_n |->
		!flash_ce_n && flash_oe_n && !flash_a9_hv && dq_oe[7:0] == 8'hFF)
		else $error("write levels wrong");
	// the strobe stays low for one cycle, which already covers the pulse width
	a_write_pulse: assert property ($fell(flash_we_n) |->
		$stable(flash_addr)
		##1 flash_we_n && $stable(flash_addr) && $stable(dq_o))
		else $error("write pulse unstable");
	a_write_release: assert property ($rose(flash_we_n) |=>
		flash_ce_n && dq_oe[7:0] == 8'h00)
		else $error("write not released");
	a_reset_width: assert property ($rose(flash_rst_n) |->
		rst_len_r >= 5'h0A)
		else $error("reset pulse short");
	a_hv_address: assert property (flash_a9_hv && !flash_oe_n |->
		!flash_addr[6] && flash_addr[3:2] == 2'h0)
		else $error("identifier address wrong");
	a_accel_level: assert property (flash_acc_hv |-> !flash_wp_low)
		else $error("protect pin conflict");
	// a refused op starts no cycle; the read hold window may still run out
	a_bad_refused: assert property (take && cmd_op[2:1] == 2'h3 |->
		(flash_we_n && $stable(flash_addr))[*3] and
		##1 (rsp_valid && rsp_err))
		else $error("bad op not refused");
	a_count_refused: assert property (take && cmd_op == 3'h3 &&
		!byte_mode && cmd_count[5] |-> ##1 rsp_valid && rsp_err)
		else $error("count not refused");
	a_rsp_pulse: assert property (rsp_valid |=>
		!rsp_valid && cmd_ready)
		else $error("response not one cycle");
endmodule
bind nfbbp_ctrl nfbbp_ctrl_chk #(.AW(AW)) u_nfbbp_ctrl_chk (
	.clk_sys(clk_sys), .srst(srst), .cmd_valid(cmd_valid),
	.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_count(cmd_count),
	.byte_mode(byte_mode),
	.rsp_valid(rsp_valid), .rsp_err(rsp_err), .flash_addr(flash_addr),
	.flash_a9_hv(flash_a9_hv), .flash_ce_n(flash_ce_n),
	.flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
	.flash_rst_n(flash_rst_n), .flash_wp_low(flash_wp_low),
	.flash_acc_hv(flash_acc_hv), .dq_o(dq_o), .dq_oe(dq_oe)
);

// file: tb/nfbbp_flash_model.sv
// nfbbp_flash_model.sv: behavioural parallel nor flash device
`timescale 1ns/10ps
`include "nfbbp_defs.vh"
module nfbbp_flash_model #(
	parameter MAKER = 8'h5A,
	parameter BUSY_NS = 2000
) (
	input wire [22:0] flash_addr,
	input wire flash_a9_hv,
	input wire flash_ce_n,
	input wire flash_oe_n,
	input wire flash_we_n,
	input wire flash_rst_n,
	input wire flash_byte_n,
	input wire flash_wp_low,
	input wire flash_acc_hv,
	input wire [15:0] dq_o,
	input wire [15:0] dq_oe,
	output reg [15:0] dq_i,
	output reg ready_busy_n
);
	reg [15:0] mem [0:255];
	reg [15:0] bd [0:31];
	reg [7:0] ba [0:31];
	reg [15:0] hold = 16'h0000;
	reg [15:0] rd;
	reg [22:0] wa;
	reg [17:0] pg;
	reg [2:0] st = 3'h0;
	reg [5:0] n;
	reg [5:0] left;
	integer i;
	wire lsb = dq_oe[15] & dq_o[15];
	initial begin
		ready_busy_n = 1'b1;
		for (i = 0; i < 256; i = i + 1)
			mem[i] = {~i[7:0], i[7:0]};
	end
	// **********
	// read side
	// **********
	always @* begin
		rd = mem[flash_addr[7:0]];
		if (flash_a9_hv) begin
			case (flash_addr[1:0])
			2'h0: rd = {8'h00, MAKER};
			2'h2: rd = {15'h0000, flash_addr[22:16] == 7'h01};
			default: rd = 16'h0019;
			endcase
		end
		// released lines show the inverse, never a stale copy
		if (flash_rst_n && !flash_ce_n && !flash_oe_n)
			dq_i = flash_byte_n ? rd :
				{~hold[15:8], lsb ? rd[15:8] : rd[7:0]};
		else
			dq_i = ~hold;
	end
	always @(posedge flash_oe_n)
		hold <= dq_i;
	// **********
	// write side
	// **********
	task pgm(input [7:0] a, input [15:0] d);
		if (!flash_wp_low || wa[22:16] != 7'h00)
			mem[a] = mem[a] & d;
	endtask
	task busy;
		begin
			st = 3'h0;
			ready_busy_n = 1'b0;
			#(BUSY_NS);
			ready_busy_n = 1'b1;
		end
	endtask
	always @(negedge flash_rst_n)
		st = 3'h0;
	always @(negedge flash_we_n) begin
		if (!flash_ce_n && flash_oe_n)
			wa = flash_addr;
	end
	always @(posedge flash_we_n) begin
		if (flash_rst_n && !flash_ce_n && flash_oe_n) begin
			case (st)
			3'h0: st = dq_o[7:0] == `NFBBP_CMD_UNLK1 ? 3'h1 :
				dq_o[7:0] == `NFBBP_CMD_PROG && flash_acc_hv ? 3'h3 : 3'h0;
			3'h1: st = dq_o[7:0] == `NFBBP_CMD_UNLK2 ? 3'h2 : 3'h0;
			3'h2: st = dq_o[7:0] == `NFBBP_CMD_PROG ? 3'h3 :
				dq_o[7:0] == `NFBBP_CMD_BUFLD ? 3'h4 : 3'h0;
			3'h3: begin
				pgm(wa[7:0], dq_o);
				busy;
			end
			3'h4: begin
				n = 6'h00;
				left = dq_o[5:0];
				st = 3'h5;
			end
			3'h5: begin
				if (n == 6'h00)
					pg = wa[22:5];
				ba[n[4:0]] = wa[7:0];
				bd[n[4:0]] = dq_o;
				n = n + 6'h01;
				st = wa[22:5] != pg ? 3'h7 : n > left ? 3'h6 : 3'h5;
			end
			3'h6: begin
				if (dq_o[7:0] == `NFBBP_CMD_BUFGO) begin
					for (i = 0; i < n; i = i + 1)
						pgm(ba[i], bd[i]);
					busy;
				end else
					st = 3'h7;
			end
			default: st = dq_o[7:0] == `NFBBP_CMD_ABTRST ? 3'h0 : 3'h7;
			endcase
		end
	end
endmodule

// file: tb/tb_top.sv
// tb_top.sv: self-checking bench for the nor flash host controller
`timescale 1ns/10ps
`include "nfbbp_defs.vh"
`define CHK(nm, e, g) begin checked = checked + 1; if ((g) !== (e)) begin \
	num_errors = num_errors + 1; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top;
	localparam MAKER = 8'h5A; // arbitrary maker code
	reg clk_sys = 1'b0, srst = 1'b1, cmd_valid = 1'b0, cmd_lsb = 1'b0;
	reg byte_mode = 1'b0, wp_protect = 1'b0, accel_en = 1'b0, wd_valid = 1'b0;
	reg [2:0] cmd_op = 3'h0;
	reg [22:0] cmd_addr = 23'h00_0000;
	reg [15:0] cmd_data = 16'h0000, wd_data = 16'h1234, w;
	reg [5:0] cmd_count = 6'h00;
	reg [1:0] cmd_id_sel = 2'h0;
	wire cmd_ready, wd_ready, rsp_valid, rsp_err, flash_a9_hv, flash_ce_n;
	wire flash_oe_n, flash_we_n, flash_rst_n, flash_byte_n, flash_wp_low;
	wire flash_acc_hv, ready_busy_n;
	wire [15:0] rsp_data, dq_o, dq_oe, dq_i;
	wire [22:0] flash_addr;
	integer num_errors = 0, checked = 0, cyc = 0, k, lat;
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (wd_valid && wd_ready)
			wd_data <= wd_data + 16'h0101;
	end
	nfbbp_ctrl #(.AW(23), .PROG_TMO(400)) u_nfbbp_ctrl (.clk_sys(clk_sys),
		.srst(srst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_lsb(cmd_lsb),
		.cmd_data(cmd_data), .cmd_count(cmd_count), .cmd_id_sel(cmd_id_sel),
		.byte_mode(byte_mode), .wp_protect(wp_protect), .accel_en(accel_en),
		.wd_valid(wd_valid), .wd_ready(wd_ready), .wd_data(wd_data),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
		.flash_addr(flash_addr), .flash_a9_hv(flash_a9_hv),
		.flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
		.flash_we_n(flash_we_n), .flash_rst_n(flash_rst_n),
		.flash_byte_n(flash_byte_n), .flash_wp_low(flash_wp_low),
		.flash_acc_hv(flash_acc_hv), .dq_o(dq_o), .dq_oe(dq_oe),
		.dq_i(dq_i), .ready_busy_n(ready_busy_n));
	nfbbp_flash_model #(.MAKER(MAKER)) u_nfbbp_flash_model (
		.flash_addr(flash_addr), .flash_a9_hv(flash_a9_hv),
		.flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
		.flash_we_n(flash_we_n), .flash_rst_n(flash_rst_n),
		.flash_byte_n(flash_byte_n), .flash_wp_low(flash_wp_low),
		.flash_acc_hv(flash_acc_hv), .dq_o(dq_o), .dq_oe(dq_oe),
		.dq_i(dq_i), .ready_busy_n(ready_busy_n));
	// **********
	// shared tasks
	// **********
	task complete_run;
		begin
			$display("errors %0d checks %0d", num_errors, checked);
			if (num_errors == 0 && checked > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	// a hang is cut short by the cycle watchdog below
	task op(input [2:0] o, input [22:0] a, input [15:0] d);
		begin
			cmd_op <= o;
			cmd_addr <= a;
			cmd_data <= d;
			cmd_valid <= 1'b1;
			@(posedge clk_sys);
			while (cmd_ready !== 1'b1)
				@(posedge clk_sys);
			cmd_valid <= 1'b0;
			lat = 0;
			@(posedge clk_sys);
			while (rsp_valid !== 1'b1) begin
				lat = lat + 1;
				@(posedge clk_sys);
			end
		end
	endtask
	task rd(input [22:0] a, input [15:0] e);
		begin
			op(3'h0, a, 16'h0000);
			`CHK("read", e, rsp_data)
		end
	endtask
	function [15:0] pat(input [7:0] i);
		pat = {~i, i};
	endfunction
	// **********
	// scenarios
	// **********
	task t_read;
		begin
			rd(23'h00_0010, 16'hEF10);
			k = lat;
			rd(23'h00_0013, 16'hEC13);
			`CHK("page time", 1'b1, lat < k)
			rd(23'h00_0028, 16'hD728);
			`CHK("new page time", k, lat)
			byte_mode <= 1'b1;
			op(3'h0, 23'h00_0021, 16'h0000);
			`CHK("byte low", 8'h21, rsp_data[7:0])
			`CHK("width pin", 1'b0, flash_byte_n)
			cmd_lsb <= 1'b1;
			op(3'h0, 23'h00_0021, 16'h0000);
			`CHK("byte high", 8'hDE, rsp_data[7:0])
			cmd_lsb <= 1'b0;
			byte_mode <= 1'b0;
		end
	endtask
	task t_ids;
		begin
			op(3'h1, 23'h00_0000, 16'h0000);
			`CHK("maker", MAKER, rsp_data[7:0])
			cmd_id_sel <= 2'h1;
			op(3'h1, 23'h01_0000, 16'h0000);
			`CHK("locked", 8'h01, rsp_data[7:0])
			op(3'h1, 23'h02_0000, 16'h0000);
			`CHK("unlocked", 8'h00, rsp_data[7:0])
			cmd_id_sel <= 2'h2;
			op(3'h1, 23'h00_0000, 16'h0000);
			`CHK("indicator", 8'h19, rsp_data[7:0])
			cmd_id_sel <= 2'h0;
		end
	endtask
	task t_prog;
		begin
			op(3'h2, 23'h00_0040, 16'h0F0F);
			`CHK("program err", 1'b0, rsp_err)
			rd(23'h00_0040, 16'h0F00);
			accel_en <= 1'b1;
			op(3'h2, 23'h00_0041, 16'h00FF);
			rd(23'h00_0041, 16'h0041);
			accel_en <= 1'b0;
			wp_protect <= 1'b1;
			op(3'h2, 23'h00_0002, 16'h0000);
			rd(23'h00_0002, 16'hFD02);
			wp_protect <= 1'b0;
		end
	endtask
	task t_buf;
		begin
			w = wd_data;
			cmd_count <= 6'h1F;
			op(3'h3, 23'h00_00A0, 16'h0000);
			`CHK("buffer err", 1'b0, rsp_err)
			for (k = 0; k < 32; k = k + 1)
				rd(23'h00_00A0 + k, pat(8'hA0 + k) & (w + k * 16'h0101));
			cmd_count <= 6'h20;
			op(3'h3, 23'h00_00C0, 16'h0000);
			`CHK("count refused", 1'b1, rsp_err)
			cmd_count <= 6'h03;
			op(3'h3, 23'h00_00DE, 16'h0000);
			`CHK("page refused", 1'b1, rsp_err)
		end
	endtask
	task t_misc;
		begin
			op(3'h6, 23'h00_0000, 16'h0000);
			`CHK("op six", 1'b1, rsp_err)
			op(3'h7, 23'h00_0000, 16'h0000);
			`CHK("op seven", 1'b1, rsp_err)
			op(3'h4, 23'h00_0000, 16'h0000);
			`CHK("abort seq", 1'b0, rsp_err)
			op(3'h5, 23'h00_0000, 16'h0000);
			`CHK("hw reset", 1'b0, rsp_err)
			rd(23'h00_0010, 16'hEF10);
		end
	endtask
	always @(posedge clk_sys) begin
		cyc = cyc + 1;
		if (cyc == 40000) begin
			num_errors = num_errors + 1;
			complete_run;
		end
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		wd_valid <= 1'b1;
		t_read;
		t_ids;
		t_prog;
		t_buf;
		t_misc;
		complete_run;
	end
endmodule

// file: verilog/nfbbp_ctrl.v
// nfbbp_ctrl.v: host sequencer driving a parallel nor flash bus
// How it works
// - maker id read uses high voltage on A9, A6,A3..A0 low.
// - read: address, chip select and output enable low, write high.
// - write: address, select low, output high, data, pulse strobe.
// - host never issues undefined command writes.
// - reset pin low for minimum width returns device to read.
// - two unlocks, load command at sector, then count minus one.
// - confirm command starts programming; device returns to read.
// - abort shows Q1 set; host sends the abort reset sequence.
`timescale 1ns/10ps
`include "nfbbp_defs.vh"

module nfbbp_ctrl #(
	parameter AW = 23,
	parameter PROG_TMO = `NFBBP_PROG_TMO
) (
	input wire clk_sys,
	input wire srst,
	input wire cmd_valid,
	output wire cmd_ready,
	input wire [2:0] cmd_op,
	input wire [AW-1:0] cmd_addr,
	input wire cmd_lsb,
	input wire [15:0] cmd_data,
	input wire [5:0] cmd_count,
	input wire [1:0] cmd_id_sel,
	input wire byte_mode,
	input wire wp_protect,
	input wire accel_en,
	input wire wd_valid,
	output wire wd_ready,
	input wire [15:0] wd_data,
	output wire rsp_valid,
	output reg [15:0] rsp_data,
	output reg rsp_err,
	output wire [AW-1:0] flash_addr,
	output wire flash_a9_hv,
	output wire flash_ce_n,
	output wire flash_oe_n,
	output wire flash_we_n,
	output wire flash_rst_n,
	output wire flash_byte_n,
	output wire flash_wp_low,
	output wire flash_acc_hv,
	output wire [15:0] dq_o,
	output wire [15:0] dq_oe,
	input wire [15:0] dq_i,
	input wire ready_busy_n
);

	// ****************************************************************
	// constants and state
	// ****************************************************************
	localparam [19:0] RP_CYC = `NFBBP_CYC_UP(`NFBBP_T_RP_NS);
	localparam [19:0] RDY_CYC = `NFBBP_CYC_UP(`NFBBP_T_READY1_NS);
	localparam [19:0] BSY_CYC = `NFBBP_CYC_UP(`NFBBP_T_BUSY_NS);
	localparam [19:0] TMO_CYC = PROG_TMO;
	localparam [2:0] M_IDLE = 3'h0;
	localparam [2:0] M_GO = 3'h1;
	localparam [2:0] M_CYC = 3'h2;
	localparam [2:0] M_BUSY = 3'h3;
	localparam [2:0] M_RLO = 3'h4;
	localparam [2:0] M_RWAIT = 3'h5;
	localparam [2:0] M_RSP = 3'h6;
	localparam [2:0] S_RD = 3'h7;

	reg [2:0] st_r, op_r, stp_r;
	reg [1:0] idsel_r;
	reg [AW:0] base_r;
	reg [15:0] data_r;
	reg [5:0] cnt_r, idx_r;
	reg [19:0] tmr_r;
	reg byte_r, wpl_r, acc_r, rst_n_r, rb_s1, rb_s2;
	reg [AW:0] fa;
	reg [7:0] cmd;
	reg [15:0] wr_dat;
	wire [AW:0] cur_fa, req_fa, last_fa;
	wire [15:0] eng_rdata;
	wire eng_done, is_rd, is_load, start, buf_bad;

	// a byte-wide command sits on the low lane, upper lane zero
	function [15:0] cmd_word;
		input [7:0] c;
		begin
			cmd_word = {8'h00, c};
		end
	endfunction

	// ****************************************************************
	// address arithmetic
	// ****************************************************************
	assign cur_fa = base_r + (byte_r ? {{(AW-5){1'b0}}, idx_r}
		: {{(AW-6){1'b0}}, idx_r, 1'b0});
	assign req_fa = {cmd_addr, cmd_lsb & byte_mode};
	assign last_fa = req_fa + (byte_mode ? {{(AW-5){1'b0}}, cmd_count}
		: {{(AW-6){1'b0}}, cmd_count, 1'b1});
	// refuse a load list that overruns the buffer or leaves its page
	assign buf_bad = (~byte_mode & (cmd_count > `NFBBP_BUF_WORD_MAX)) |
		(last_fa[AW:`NFBBP_BUF_PAGE_BITS] !=
		req_fa[AW:`NFBBP_BUF_PAGE_BITS]);

	assign is_rd = (stp_r == S_RD);
	assign is_load = (op_r == `NFBBP_OP_BUF) & (stp_r == 3'h4);
	assign start = (st_r == M_GO) & (~is_load | wd_valid);
	assign wd_ready = (st_r == M_GO) & is_load;
	assign cmd_ready = (st_r == M_IDLE);
	assign rsp_valid = (st_r == M_RSP);
	assign flash_rst_n = rst_n_r;
	assign flash_byte_n = ~byte_r;
	assign flash_wp_low = wpl_r;
	assign flash_acc_hv = acc_r;

	// ****************************************************************
	// address and data of the current step
	// ****************************************************************
	always @* begin
		fa = cur_fa;
		cmd = `NFBBP_CMD_UNLK1;
		wr_dat = data_r;
		case (stp_r)
		3'h0: begin
			fa = byte_r ? `NFBBP_UA1_B : `NFBBP_UA1_W;
			wr_dat = cmd_word(`NFBBP_CMD_UNLK1);
		end
		3'h1: begin
			fa = byte_r ? `NFBBP_UA2_B : `NFBBP_UA2_W;
			wr_dat = cmd_word(`NFBBP_CMD_UNLK2);
		end
		3'h2: begin
			fa = byte_r ? `NFBBP_UA1_B : `NFBBP_UA1_W;
			case (op_r)
			`NFBBP_OP_PROG: cmd = `NFBBP_CMD_PROG;
			`NFBBP_OP_ABORT: cmd = `NFBBP_CMD_ABTRST;
			default: begin
				fa = base_r;
				cmd = `NFBBP_CMD_BUFLD;
			end
			endcase
			wr_dat = cmd_word(cmd);
		end
		3'h3: begin
			if (op_r == `NFBBP_OP_BUF) begin
				fa = base_r;
				wr_dat = {10'h000, cnt_r};
			end
		end
		3'h4: wr_dat = wd_data;
		3'h5: begin
			fa = base_r;
			wr_dat = cmd_word(`NFBBP_CMD_BUFGO);
		end
		default: begin
			if (op_r == `NFBBP_OP_ID) begin
				case (idsel_r)
				`NFBBP_ID_LOCK:
					fa = {base_r[AW:8], `NFBBP_IDA_LOCK, 1'b0};
				`NFBBP_ID_SECIND:
					fa = {base_r[AW:8], `NFBBP_IDA_SECIND, 1'b0};
				default:
					fa = {base_r[AW:8], `NFBBP_IDA_MAKER, 1'b0};
				endcase
			end
		end
		endcase
	end

	// ****************************************************************
	// sequencer
	// ****************************************************************
	always @(posedge clk_sys) begin
		if (srst) begin
			st_r <= M_IDLE;
			op_r <= `NFBBP_OP_READ;
			stp_r <= 3'h0;
			idsel_r <= 2'h0;
			base_r <= {(AW+1){1'b0}};
			data_r <= 16'h0000;
			cnt_r <= 6'h00;
			idx_r <= 6'h00;
			tmr_r <= 20'h0_0000;
			byte_r <= 1'b0;
			wpl_r <= 1'b0;
			acc_r <= 1'b0;
			rst_n_r <= 1'b1;
			rb_s1 <= 1'b1;
			rb_s2 <= 1'b1;
			rsp_data <= 16'h0000;
			rsp_err <= 1'b0;
		end else begin
			rb_s1 <= ready_busy_n;
			rb_s2 <= rb_s1;
			case (st_r)
			M_IDLE: begin
				// pin modes change only between operations
				byte_r <= byte_mode;
				wpl_r <= wp_protect;
				acc_r <= accel_en;
				if (cmd_valid) begin
					op_r <= cmd_op;
					base_r <= req_fa;
					data_r <= cmd_data;
					cnt_r <= cmd_count;
					idsel_r <= cmd_id_sel;
					idx_r <= 6'h00;
					tmr_r <= 20'h0_0000;
					rsp_err <= 1'b0;
					rsp_data <= 16'h0000;
					st_r <= M_GO;
					case (cmd_op)
					`NFBBP_OP_READ, `NFBBP_OP_ID: stp_r <= S_RD;
					`NFBBP_OP_PROG:
						stp_r <= accel_en ? 3'h2 : 3'h0;
					`NFBBP_OP_BUF: begin
						stp_r <= 3'h0;
						if (buf_bad) begin
							rsp_err <= 1'b1;
							st_r <= M_RSP;
						end
					end
					`NFBBP_OP_ABORT: stp_r <= 3'h0;
					`NFBBP_OP_HWRST: st_r <= M_RLO;
					default: begin
						// never put an undefined command on the bus
						rsp_err <= 1'b1;
						st_r <= M_RSP;
					end
					endcase
				end
			end
			M_GO: if (start) st_r <= M_CYC;
			M_CYC: begin
				if (eng_done) begin
					st_r <= M_GO;
					if (is_rd) begin
						rsp_data <= eng_rdata;
						st_r <= M_RSP;
					end else if (op_r == `NFBBP_OP_ABORT &&
						stp_r == 3'h2) begin
						st_r <= M_RSP;
					end else if (op_r == `NFBBP_OP_PROG &&
						stp_r == 3'h3) begin
						st_r <= M_BUSY;
					end else if (stp_r == 3'h5) begin
						st_r <= M_BUSY;
					end else if (is_load) begin
						idx_r <= idx_r + 6'h01;
						if (idx_r == cnt_r)
							stp_r <= 3'h5;
					end else begin
						stp_r <= stp_r + 3'h1;
					end
				end
			end
			M_BUSY: begin
				// give the busy output time to fall before trusting it
				tmr_r <= tmr_r + 20'h0_0001;
				if (tmr_r >= BSY_CYC && rb_s2) begin
					st_r <= M_RSP;
				end else if (tmr_r == TMO_CYC) begin
					rsp_err <= 1'b1;
					st_r <= M_RSP;
				end
			end
			M_RLO: begin
				rst_n_r <= 1'b0;
				tmr_r <= tmr_r + 20'h0_0001;
				if (tmr_r == RP_CYC) begin
					rst_n_r <= 1'b1;
					tmr_r <= 20'h0_0000;
					st_r <= M_RWAIT;
				end
			end
			M_RWAIT: begin
				tmr_r <= tmr_r + 20'h0_0001;
				if (tmr_r >= BSY_CYC && rb_s2) begin
					st_r <= M_RSP;
				end else if (tmr_r == RDY_CYC) begin
					rsp_err <= ~rb_s2;
					st_r <= M_RSP;
				end
			end
			M_RSP: st_r <= M_IDLE;
			default: st_r <= M_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// pin cycle engine
	// ****************************************************************
	nfbbp_cycle #(
		.AW(AW)
	) u_cycle (
		.clk_sys(clk_sys),
		.srst(srst),
		.start(start),
		.wr(~is_rd),
		.a9_hv(op_r == `NFBBP_OP_ID),
		.byte_mode(byte_r),
		.addr(fa[AW:1]),
		.lsb(fa[0]),
		.wdata(wr_dat),
		.done(eng_done),
		.rdata(eng_rdata),
		.flash_addr(flash_addr),
		.flash_a9_hv(flash_a9_hv),
		.flash_ce_n(flash_ce_n),
		.flash_oe_n(flash_oe_n),
		.flash_we_n(flash_we_n),
		.dq_o(dq_o),
		.dq_oe(dq_oe),
		.dq_i(dq_i)
	);

endmodule

// file: verilog/nfbbp_cycle.v
// nfbbp_cycle.v: one read or write cycle on the flash pins
`timescale 1ns/10ps
`include "nfbbp_defs.vh"

module nfbbp_cycle #(
	parameter AW = 23
) (
	input wire clk_sys,
	input wire srst,
	input wire start,
	input wire wr,
	input wire a9_hv,
	input wire byte_mode,
	input wire [AW-1:0] addr,
	input wire lsb,
	input wire [15:0] wdata,
	output reg done,
	output reg [15:0] rdata,
	output wire [AW-1:0] flash_addr,
	output wire flash_a9_hv,
	output wire flash_ce_n,
	output wire flash_oe_n,
	output wire flash_we_n,
	output wire [15:0] dq_o,
	output wire [15:0] dq_oe,
	input wire [15:0] dq_i
);

	localparam [7:0] ACC_CYC = `NFBBP_CYC_UP(`NFBBP_T_ACC_NS)
		+ `NFBBP_SYNC_CYC;
	localparam [7:0] PG_CYC = `NFBBP_CYC_UP(`NFBBP_T_PAGE_NS)
		+ `NFBBP_SYNC_CYC;
	localparam [7:0] WP_CYC = `NFBBP_CYC_UP(`NFBBP_T_WP_NS);
	localparam [7:0] WPH_CYC = `NFBBP_CYC_UP(`NFBBP_T_WPH_NS);
	localparam [3:0] HOLD = `NFBBP_HOLD_CYC;
	localparam [2:0] E_IDLE = 3'h0;
	localparam [2:0] E_RD = 3'h1;
	localparam [2:0] E_WSET = 3'h2;
	localparam [2:0] E_WLO = 3'h3;
	localparam [2:0] E_WHI = 3'h4;

	reg [2:0] st_r;
	reg [7:0] cnt_r;
	reg [3:0] hold_r;
	reg ce_n_r, oe_n_r, we_n_r, a9_r, byte_r, lsb_r, drv_r;
	reg [AW-1:0] addr_r;
	reg [15:0] wd_r, dq_s1, dq_s2;
	wire page_hit;

	assign flash_addr = addr_r;
	assign flash_a9_hv = a9_r;
	assign flash_ce_n = ce_n_r;
	assign flash_oe_n = oe_n_r;
	assign flash_we_n = we_n_r;
	// byte mode: pin 15 carries the lowest address bit, 8..14 float
	assign dq_o = byte_r ? {lsb_r, 7'h00, wd_r[7:0]} : wd_r;
	assign dq_oe = {byte_r | drv_r, {7{drv_r & ~byte_r}},
		{8{drv_r}}};
	// same page, chip still selected, same mode: shorter page delay
	assign page_hit = ~ce_n_r & ~oe_n_r & (a9_r == a9_hv) &
		(byte_r == byte_mode) &
		(addr_r[AW-1:3] == addr[AW-1:3]);

	always @(posedge clk_sys) begin
		if (srst) begin
			st_r <= E_IDLE;
			cnt_r <= 8'h00;
			hold_r <= 4'h0;
			ce_n_r <= 1'b1;
			oe_n_r <= 1'b1;
			we_n_r <= 1'b1;
			a9_r <= 1'b0;
			byte_r <= 1'b0;
			lsb_r <= 1'b0;
			drv_r <= 1'b0;
			addr_r <= {AW{1'b0}};
			wd_r <= 16'h0000;
			dq_s1 <= 16'h0000;
			dq_s2 <= 16'h0000;
			done <= 1'b0;
			rdata <= 16'h0000;
		end else begin
			dq_s1 <= dq_i;
			dq_s2 <= dq_s1;
			done <= 1'b0;
			case (st_r)
			E_IDLE: begin
				if (start) begin
					addr_r <= addr;
					lsb_r <= lsb;
					a9_r <= a9_hv;
					byte_r <= byte_mode;
					wd_r <= wdata;
					ce_n_r <= 1'b0;
					if (wr) begin
						oe_n_r <= 1'b1;
						st_r <= E_WSET;
					end else begin
						oe_n_r <= 1'b0;
						cnt_r <= page_hit ? PG_CYC : ACC_CYC;
						st_r <= E_RD;
					end
				end else if (hold_r != 4'h0) begin
					hold_r <= hold_r - 4'h1;
				end else begin
					ce_n_r <= 1'b1;
					oe_n_r <= 1'b1;
					a9_r <= 1'b0;
				end
			end
			E_RD: begin
				cnt_r <= cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					// data has passed the two-stage synchroniser
					rdata <= byte_r ? {8'h00, dq_s2[7:0]} : dq_s2;
					done <= 1'b1;
					hold_r <= HOLD;
					st_r <= E_IDLE;
				end
			end
			E_WSET: begin
				// oe_n went high a cycle ago, so no fight on the bus
				drv_r <= 1'b1;
				we_n_r <= 1'b0;
				cnt_r <= WP_CYC;
				st_r <= E_WLO;
			end
			E_WLO: begin
				cnt_r <= cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					we_n_r <= 1'b1;
					cnt_r <= WPH_CYC;
					st_r <= E_WHI;
				end
			end
			E_WHI: begin
				cnt_r <= cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					drv_r <= 1'b0;
					ce_n_r <= 1'b1;
					hold_r <= 4'h0;
					done <= 1'b1;
					st_r <= E_IDLE;
				end
			end
			default: st_r <= E_IDLE;
			endcase
		end
	end

endmodule

// file: verilog/nfbbp_defs.vh
// nfbbp_defs.vh: constants of the parallel nor flash host controller
`ifndef NFBBP_DEFS_VH
`define NFBBP_DEFS_VH

// ****************************************************************
// timing, in ns as printed, and rounding to clk_sys cycles
// ****************************************************************
`define NFBBP_CLK_NS 50
`define NFBBP_CYC_UP(ns) (((ns) + `NFBBP_CLK_NS - 1) / `NFBBP_CLK_NS)
`define NFBBP_T_ACC_NS 90
`define NFBBP_T_PAGE_NS 25
`define NFBBP_T_WP_NS 35
`define NFBBP_T_WPH_NS 20
`define NFBBP_T_RP_NS 500
`define NFBBP_T_READY1_NS 20000
`define NFBBP_T_BUSY_NS 90
`define NFBBP_SYNC_CYC 2
`define NFBBP_HOLD_CYC 3
`define NFBBP_PROG_TMO 100000

// ****************************************************************
// user operations and identifier selections
// ****************************************************************
`define NFBBP_OP_READ 3'h0
`define NFBBP_OP_ID 3'h1
`define NFBBP_OP_PROG 3'h2
`define NFBBP_OP_BUF 3'h3
`define NFBBP_OP_ABORT 3'h4
`define NFBBP_OP_HWRST 3'h5
`define NFBBP_ID_MAKER 2'h0
`define NFBBP_ID_LOCK 2'h1
`define NFBBP_ID_SECIND 2'h2
`define NFBBP_IDA_MAKER 7'h00
`define NFBBP_IDA_LOCK 7'h02
`define NFBBP_IDA_SECIND 7'h03

// ****************************************************************
// command codes and unlock addresses (byte addresses)
// ****************************************************************
`define NFBBP_CMD_UNLK1 8'hAA
`define NFBBP_CMD_UNLK2 8'h55
`define NFBBP_CMD_PROG 8'hA0
`define NFBBP_CMD_BUFLD 8'h25
`define NFBBP_CMD_BUFGO 8'h29
`define NFBBP_CMD_ABTRST 8'hF0
`define NFBBP_UA1_W 24'h00_0AAA
`define NFBBP_UA2_W 24'h00_0554
`define NFBBP_UA1_B 24'h00_0AAA
`define NFBBP_UA2_B 24'h00_0555

// ****************************************************************
// write buffer geometry
// ****************************************************************
`define NFBBP_BUF_PAGE_BITS 6
`define NFBBP_BUF_WORD_MAX 6'h1F

`endif
